/* File: pwr_seq.sv */
// Purpose: Power button and wake sequencer with LAN connector LED drive.
// Assumes: One standby clock; pins pass a three-stage synchroniser.
// Notes:   Long counts are top-level parameters so simulation can shorten them.
`timescale 1ns/1ns
`default_nettype none

module pwr_seq #(
   parameter int unsigned LONG_CYC   = pwr_seq_pkg::LONG_PRESS_CYC,
   parameter int unsigned DEB_CYC    = pwr_seq_pkg::DEBOUNCE_CYC,
   parameter int unsigned BLINK_CYCS = pwr_seq_pkg::BLINK_CYC
) (
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   // Front panel and wake pins, active high after board inversion.
   input  wire logic                   pwr_sw,
   input  wire pwr_seq_pkg::wake_src_s wake_pins,
   // Operating system requests, same clock domain.
   input  wire pwr_seq_pkg::sleep_req_e os_req,
   input  wire logic                   ac_present,
   input  wire logic                   sw_to_sleep,
   // LAN status pins.
   input  wire pwr_seq_pkg::lan_stat_s lan_pins,
   // Supply and state outputs.
   output var  pwr_seq_pkg::supply_s    supply_ff,
   output var  pwr_seq_pkg::pwr_state_e state_ff,
   // LAN LEDs.
   output logic                        led_green_ff,
   output logic                        led_yellow_ff,
   output logic                        led_bright_ff
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers: three stages, accepted when stages two and three
   // agree, so a single metastable sample never counts.

   localparam int unsigned NSYNC = 9;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] s3_ff;
   logic [NSYNC-1:0] clean_ff;
   logic [NSYNC-1:0] raw_in;

   assign raw_in = {pwr_sw, wake_pins, lan_pins};

   // Chain of three flip-flops per pin.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Clean value updates only where stages two and three agree.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         clean_ff <= '0;
      end else begin
         clean_ff <= (s2_ff & s3_ff) | (clean_ff & (s2_ff | s3_ff));
      end
   end

   logic                   sw_sync;
   pwr_seq_pkg::wake_src_s wk;
   pwr_seq_pkg::lan_stat_s lan;
   assign sw_sync = clean_ff[8];
   assign wk      = clean_ff[7:3];
   assign lan     = clean_ff[2:0];

   ////////////////////////////////////////////////////////////////////////
   // Switch debounce and press timing.

   logic [pwr_seq_pkg::CNT_W-1:0] deb_cnt_ff;
   logic                          sw_deb_ff;
   logic [pwr_seq_pkg::CNT_W-1:0] press_cnt_ff;
   logic                          long_done_ff;
   logic                          short_evt_ff;
   logic                          long_evt_ff;

   // Debounced level follows the input only after it held steady.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         deb_cnt_ff <= '0;
         sw_deb_ff  <= 1'b0;
      end else if (sw_sync == sw_deb_ff) begin
         deb_cnt_ff <= '0;
      end else if (deb_cnt_ff >= DEB_CYC[pwr_seq_pkg::CNT_W-1:0] - 1) begin
         deb_cnt_ff <= '0;
         sw_deb_ff  <= sw_sync;
      end else begin
         deb_cnt_ff <= deb_cnt_ff + 1'b1;
      end
   end

   // Press length counter; long fires at the threshold, short at release.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         press_cnt_ff <= '0;
         long_done_ff <= 1'b0;
         short_evt_ff <= 1'b0;
         long_evt_ff  <= 1'b0;
      end else begin
         short_evt_ff <= 1'b0;
         long_evt_ff  <= 1'b0;
         if (sw_deb_ff) begin
            if (!long_done_ff) begin
               if (press_cnt_ff >= LONG_CYC[pwr_seq_pkg::CNT_W-1:0] - 1) begin
                  long_done_ff <= 1'b1;
                  long_evt_ff  <= 1'b1;
               end else begin
                  press_cnt_ff <= press_cnt_ff + 1'b1;
               end
            end
         end else begin
            // Release after a long press was already acted on is silent.
            short_evt_ff <= (press_cnt_ff != '0) && !long_done_ff;
            press_cnt_ff <= '0;
            long_done_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake qualification.

   // Returns one when a wake source is permitted in the given state.
   function automatic logic wake_ok(input pwr_seq_pkg::pwr_state_e st,
                                    input pwr_seq_pkg::wake_src_s w,
                                    input logic sw);
      logic sleeping;
      logic common;
      sleeping = (st == pwr_seq_pkg::ST_SLEEP_S1) ||
                 (st == pwr_seq_pkg::ST_SLEEP_S3);
      common   = w.lan | w.modem | w.pme | w.rtc | sw;
      wake_ok  = ((sleeping || st == pwr_seq_pkg::ST_SOFT_OFF) && common) ||
                 (sleeping && w.usb);
   endfunction

   logic wake_now;
   // USB is left out of the S5 term by the function above.
   assign wake_now = wake_ok(state_ff, wk, short_evt_ff);

   ////////////////////////////////////////////////////////////////////////
   // Power state machine.

   pwr_seq_pkg::pwr_state_e nxt_state;

   // Next state; loss of mains outranks all, then long press, then short press or wake, then OS requests.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         pwr_seq_pkg::ST_MECH_OFF: begin
            if (ac_present) begin
               nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
            end
         end
         pwr_seq_pkg::ST_SOFT_OFF: begin
            if (wake_now) begin
               nxt_state = pwr_seq_pkg::ST_WORKING;
            end
         end
         pwr_seq_pkg::ST_WORKING: begin
            if (long_evt_ff) begin
               nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
            end else if (short_evt_ff) begin
               nxt_state = sw_to_sleep ? pwr_seq_pkg::ST_SLEEP_S3
                                       : pwr_seq_pkg::ST_SOFT_OFF;
            end else if (os_req == pwr_seq_pkg::REQ_S5) begin
               nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
            end else if (os_req == pwr_seq_pkg::REQ_S3) begin
               nxt_state = pwr_seq_pkg::ST_SLEEP_S3;
            end else if (os_req == pwr_seq_pkg::REQ_S1) begin
               nxt_state = pwr_seq_pkg::ST_SLEEP_S1;
            end
         end
         pwr_seq_pkg::ST_SLEEP_S1,
         pwr_seq_pkg::ST_SLEEP_S3: begin
            if (long_evt_ff) begin
               nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
            end else if (wake_now) begin
               nxt_state = pwr_seq_pkg::ST_WORKING;
            end
         end
         default: begin
            nxt_state = pwr_seq_pkg::ST_SOFT_OFF;
         end
      endcase
      if (!ac_present) begin
         nxt_state = pwr_seq_pkg::ST_MECH_OFF;
      end
   end

   // State register.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= pwr_seq_pkg::ST_MECH_OFF;
      end else begin
         state_ff <= nxt_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Supply controls, registered from the next state so they line up.

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         supply_ff <= '0;
      end else begin
         // Main rail only in working and S1; S5 keeps wake logic alone, S3 also keeps RAM.
         supply_ff.main_on    <= (nxt_state == pwr_seq_pkg::ST_WORKING) ||
                                 (nxt_state == pwr_seq_pkg::ST_SLEEP_S1);
         supply_ff.standby_on <= (nxt_state != pwr_seq_pkg::ST_MECH_OFF);
         supply_ff.ram_keep   <= (nxt_state == pwr_seq_pkg::ST_SLEEP_S3);
         // Cold boot flagged on going from soft-off to working; resume from S3 is warm.
         if (state_ff == pwr_seq_pkg::ST_SOFT_OFF &&
             nxt_state == pwr_seq_pkg::ST_WORKING) begin
            supply_ff.cold_boot <= 1'b1;
         end else if (state_ff == pwr_seq_pkg::ST_SLEEP_S3 &&
                      nxt_state == pwr_seq_pkg::ST_WORKING) begin
            supply_ff.cold_boot <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // LAN connector LEDs. The pulse is a free running toggle, which trades
   // exact traffic timing for a visible blink rate.

   logic [pwr_seq_pkg::CNT_W-1:0] blink_cnt_ff;
   logic                          blink_ff;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end else if (blink_cnt_ff >= BLINK_CYCS[pwr_seq_pkg::CNT_W-1:0] - 1) begin
         blink_cnt_ff <= '0;
         blink_ff     <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   // LED drive.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         led_green_ff  <= 1'b0;
         led_yellow_ff <= 1'b0;
         led_bright_ff <= 1'b0;
      end else begin
         led_green_ff  <= lan.speed_100;
         led_yellow_ff <= lan.link_up & (~lan.activity | blink_ff);
         led_bright_ff <= lan.link_up & lan.activity;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   chk_usb_s5_blocked: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == pwr_seq_pkg::ST_SOFT_OFF && ac_present && !short_evt_ff &&
       !(wk.lan | wk.modem | wk.pme | wk.rtc))
      |=> state_ff != pwr_seq_pkg::ST_WORKING)
      else $error("USB woke the system from soft-off");
   chk_usb_s3_wake: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == pwr_seq_pkg::ST_SLEEP_S3 && wk.usb && ac_present &&
       !long_evt_ff) |=> state_ff == pwr_seq_pkg::ST_WORKING)
      else $error("USB wake from S3 was missed");
   chk_rtc_s5_wake: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == pwr_seq_pkg::ST_SOFT_OFF && wk.rtc && ac_present)
      |=> state_ff == pwr_seq_pkg::ST_WORKING)
      else $error("RTC wake from soft-off was missed");
   chk_long_off: assert property (@(posedge clk) disable iff (sys_rst)
      (long_evt_ff && ac_present && state_ff != pwr_seq_pkg::ST_MECH_OFF)
      |=> state_ff == pwr_seq_pkg::ST_SOFT_OFF ##1 !supply_ff.main_on)
      else $error("Long press did not power off");
   chk_os_soft_off: assert property (@(posedge clk) disable iff (sys_rst)
      (state_ff == pwr_seq_pkg::ST_WORKING && os_req == pwr_seq_pkg::REQ_S5 &&
       !short_evt_ff && !long_evt_ff && ac_present)
      |=> !supply_ff.main_on)
      else $error("Soft-off request left main power on");
   chk_s3_ram_keep: assert property (@(posedge clk) disable iff (sys_rst)
      state_ff == pwr_seq_pkg::ST_SLEEP_S3 |-> supply_ff.ram_keep &&
      !supply_ff.main_on && supply_ff.standby_on)
      else $error("S3 supply state wrong");
   chk_short_wake: assert property (@(posedge clk) disable iff (sys_rst)
      (short_evt_ff && ac_present && state_ff == pwr_seq_pkg::ST_SLEEP_S1)
      |=> state_ff == pwr_seq_pkg::ST_WORKING)
      else $error("Short press did not wake from S1");
   chk_green_speed: assert property (@(posedge clk) disable iff (sys_rst)
      $stable(lan.speed_100) |=> led_green_ff == $past(lan.speed_100))
      else $error("Green LED does not follow speed");
   chk_yellow_nolink: assert property (@(posedge clk) disable iff (sys_rst)
      !lan.link_up |=> !led_yellow_ff && !led_bright_ff)
      else $error("Yellow LED lit without link");
   chk_debounce_hold: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(sw_deb_ff) |-> $past(sw_sync, 2))
      else $error("Switch accepted without settling");

   cov_s3_resume: cover property (@(posedge clk) disable iff (sys_rst)
      state_ff == pwr_seq_pkg::ST_SLEEP_S3 ##1
      state_ff == pwr_seq_pkg::ST_WORKING);
   cov_power_on: cover property (@(posedge clk) disable iff (sys_rst)
      state_ff == pwr_seq_pkg::ST_SOFT_OFF ##1
      state_ff == pwr_seq_pkg::ST_WORKING);
   cov_long_press: cover property (@(posedge clk) disable iff (sys_rst)
      long_evt_ff);
   cov_traffic: cover property (@(posedge clk) disable iff (sys_rst)
      led_bright_ff);

endmodule

`default_nettype wire

/* File: pwr_seq_pkg.sv */
// Purpose: Shared constants and types for the power button and wake sequencer.
// Assumes: 100 MHz standby clock.
// Notes:   Timing counts are derived from the printed times.
package pwr_seq_pkg;

   // Clock rate and derived timings.
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned LONG_PRESS_S   = 4;
   localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_S * CLK_HZ;
   localparam int unsigned DEBOUNCE_US    = 10_000;
   localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BLINK_MS       = 50;
   localparam int unsigned BLINK_CYC      = BLINK_MS * (CLK_HZ / 1_000);

   // Counter width, wide enough for the long press count.
   localparam int unsigned CNT_W = 32;

   // System power states.
   typedef enum logic [2:0] {
      ST_MECH_OFF = 3'h0,
      ST_SOFT_OFF = 3'h1,
      ST_WORKING  = 3'h2,
      ST_SLEEP_S1 = 3'h3,
      ST_SLEEP_S3 = 3'h4
   } pwr_state_e;

   // Sleep request codes from the operating system.
   typedef enum logic [1:0] {
      REQ_NONE  = 2'h0,
      REQ_S1    = 2'h1,
      REQ_S3    = 2'h2,
      REQ_S5    = 2'h3
   } sleep_req_e;

   // Wake source bundle.
   typedef struct packed {
      logic lan;
      logic modem;
      logic pme;
      logic rtc;
      logic usb;
   } wake_src_s;

   // Supply controls bundle.
   typedef struct packed {
      logic main_on;
      logic standby_on;
      logic ram_keep;
      logic cold_boot;
   } supply_s;

   // LAN status bundle.
   typedef struct packed {
      logic speed_100;
      logic link_up;
      logic activity;
   } lan_stat_s;

endpackage

/* File: pwr_panel_model.sv */
// Purpose: Front panel switch and wake source model.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   Released pins fall to the board pull-down level.
`timescale 1ns/1ns
`default_nettype none

module pwr_panel_model (
   // Clock.
   input  wire logic                   clk,
   // Pins towards the sequencer.
   output var  logic                   pwr_sw,
   output var  pwr_seq_pkg::wake_src_s wake_pins
);

   // Idle pins rest low at time zero.
   initial begin
      pwr_sw    = 1'b0;
      wake_pins = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Holds the switch for a count of cycles; a tiny count acts as bounce.
   task automatic press(input int unsigned cyc);
      pwr_sw <= 1'b1;
      repeat (cyc) @(posedge clk);
      pwr_sw <= 1'b0;
      repeat (30) @(posedge clk);
   endtask

   // Raises a wake level long enough to pass the synchroniser.
   task automatic wake(input pwr_seq_pkg::wake_src_s src);
      wake_pins <= src;
      repeat (20) @(posedge clk);
      wake_pins <= '0;
      repeat (10) @(posedge clk);
   endtask

endmodule
`default_nettype wire

/* File: test_pwr_seq.sv */
// Purpose: Self-checking bench for the power button and wake sequencer.
// Assumes: Shortened press, debounce and blink counts.
// Notes:   Expected states follow the press length and wake source tables.
`timescale 1ns/1ns
`default_nettype none

module test_pwr_seq;
   localparam int unsigned LONG = 200;
   localparam int unsigned DEB  = 4;
   localparam int unsigned BLK  = 8;
   logic                    clk;
   logic                    sys_rst;
   logic                    ac_present;
   logic                    sw_to_sleep;
   logic                    pwr_sw;
   pwr_seq_pkg::wake_src_s  wake_pins;
   pwr_seq_pkg::sleep_req_e os_req;
   pwr_seq_pkg::lan_stat_s  lan_pins;
   pwr_seq_pkg::supply_s    supply_ff;
   pwr_seq_pkg::pwr_state_e state_ff;
   logic                    led_green_ff;
   logic                    led_yellow_ff;
   logic                    led_bright_ff;
   int                      bad_count;
   int                      samples_checked;

   pwr_seq #(.LONG_CYC(LONG), .DEB_CYC(DEB), .BLINK_CYCS(BLK)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .pwr_sw(pwr_sw),
      .wake_pins(wake_pins), .os_req(os_req), .ac_present(ac_present),
      .sw_to_sleep(sw_to_sleep), .lan_pins(lan_pins),
      .supply_ff(supply_ff), .state_ff(state_ff),
      .led_green_ff(led_green_ff), .led_yellow_ff(led_yellow_ff),
      .led_bright_ff(led_bright_ff));

   pwr_panel_model i_panel (.clk(clk), .pwr_sw(pwr_sw),
      .wake_pins(wake_pins));

   // Clock at 100 MHz.
   initial clk = 1'b0;
   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Comparison and closing tasks.
   task automatic chk_state(input pwr_seq_pkg::pwr_state_e exp);
      samples_checked++;
      if (state_ff !== exp) begin
         bad_count++;
         $display("ERROR %0t state %0d expected %0d", $time, state_ff, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string id);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s is %b expected %b", $time, id, got, exp);
      end
   endtask

   task automatic results;
      $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Waits a bounded time for a state, then judges it.
   task automatic wait_state(input pwr_seq_pkg::pwr_state_e exp,
                             input int unsigned lim);
      int unsigned n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (state_ff !== exp && n < lim);
      chk_state(exp);
   endtask

   // Presents an operating system request for one cycle.
   task automatic os(input pwr_seq_pkg::sleep_req_e req);
      @(posedge clk);
      os_req <= req;
      @(posedge clk);
      os_req <= pwr_seq_pkg::REQ_NONE;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset;
      repeat (2) @(posedge clk);
      chk_state(pwr_seq_pkg::ST_MECH_OFF);
      chk_bit(supply_ff.main_on, 1'b0, "main");
      sys_rst <= 1'b0;
      wait_state(pwr_seq_pkg::ST_SOFT_OFF, 5);
      chk_bit(supply_ff.standby_on, 1'b1, "standby");
      // A bounce shorter than the debounce span must not power on.
      @(posedge clk);
      i_panel.press(2);
      chk_state(pwr_seq_pkg::ST_SOFT_OFF);
   endtask

   task automatic t_short;
      @(posedge clk);
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_WORKING, 10);
      chk_bit(supply_ff.main_on, 1'b1, "main");
      chk_bit(supply_ff.cold_boot, 1'b1, "cold");
      os(pwr_seq_pkg::REQ_S5);
      wait_state(pwr_seq_pkg::ST_SOFT_OFF, 3);
      chk_bit(supply_ff.main_on, 1'b0, "main");
      // Short press with sleep chosen suspends, a second one wakes.
      sw_to_sleep <= 1'b1;
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_WORKING, 10);
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_SLEEP_S3, 10);
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_WORKING, 10);
      sw_to_sleep <= 1'b0;
   endtask

   task automatic t_long;
      @(posedge clk);
      i_panel.press(300);
      chk_state(pwr_seq_pkg::ST_SOFT_OFF);
      chk_bit(supply_ff.main_on, 1'b0, "main");
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_WORKING, 10);
      os(pwr_seq_pkg::REQ_S3);
      wait_state(pwr_seq_pkg::ST_SLEEP_S3, 3);
      @(posedge clk);
      i_panel.press(300);
      chk_state(pwr_seq_pkg::ST_SOFT_OFF);
   endtask

   // Every source from S1 or S3, then from S5, where USB is refused.
   task automatic t_wakes;
      pwr_seq_pkg::wake_src_s src;
      for (int i = 0; i < 5; i++) begin
         src = pwr_seq_pkg::wake_src_s'(5'h10 >> i);
         os((i % 2) ? pwr_seq_pkg::REQ_S1 : pwr_seq_pkg::REQ_S3);
         wait_state((i % 2) ? pwr_seq_pkg::ST_SLEEP_S1
                            : pwr_seq_pkg::ST_SLEEP_S3, 3);
         chk_bit(supply_ff.main_on, (i % 2 == 1), "main");
         if (i % 2 == 0)
            chk_bit(supply_ff.ram_keep, 1'b1, "ram");
         @(posedge clk);
         i_panel.wake(src);
         chk_state(pwr_seq_pkg::ST_WORKING);
         if (i % 2 == 0)
            chk_bit(supply_ff.cold_boot, 1'b0, "cold");
         os(pwr_seq_pkg::REQ_S5);
         wait_state(pwr_seq_pkg::ST_SOFT_OFF, 3);
         @(posedge clk);
         i_panel.wake(src);
         chk_state((i == 4) ? pwr_seq_pkg::ST_SOFT_OFF
                            : pwr_seq_pkg::ST_WORKING);
         if (i == 4)
            i_panel.press(50);
         wait_state(pwr_seq_pkg::ST_WORKING, 10);
      end
   endtask

   task automatic t_leds;
      logic seen0;
      logic seen1;
      seen0 = 1'b0;
      seen1 = 1'b0;
      @(posedge clk);
      lan_pins <= 3'h4;
      repeat (8) @(posedge clk);
      #1;
      chk_bit(led_green_ff, 1'b1, "green");
      chk_bit(led_yellow_ff, 1'b0, "yellow");
      lan_pins <= 3'h2;
      repeat (8) @(posedge clk);
      for (int k = 0; k < 20; k++) begin
         @(posedge clk);
         #1;
         chk_bit(led_green_ff, 1'b0, "green");
         chk_bit(led_yellow_ff, 1'b1, "yellow");
      end
      lan_pins <= 3'h3;
      repeat (8) @(posedge clk);
      for (int k = 0; k < 4 * BLK; k++) begin
         @(posedge clk);
         #1;
         chk_bit(led_bright_ff, 1'b1, "bright");
         if (led_yellow_ff === 1'b0) seen0 = 1'b1;
         if (led_yellow_ff === 1'b1) seen1 = 1'b1;
      end
      chk_bit(seen0 & seen1, 1'b1, "pulse");
   endtask

   // Loss of mains drops to mechanical off with every rail down; its
   // return lands in soft-off, so the wake logic is powered again.
   task automatic t_ac;
      @(posedge clk);
      ac_present <= 1'b0;
      wait_state(pwr_seq_pkg::ST_MECH_OFF, 3);
      chk_bit(supply_ff.standby_on, 1'b0, "standby");
      chk_bit(supply_ff.main_on, 1'b0, "main");
      ac_present <= 1'b1;
      wait_state(pwr_seq_pkg::ST_SOFT_OFF, 3);
      chk_bit(supply_ff.standby_on, 1'b1, "standby");
      chk_bit(supply_ff.main_on, 1'b0, "main");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence and watchdog.
   initial begin
      bad_count       = 0;
      samples_checked = 0;
      sys_rst         = 1'b1;
      ac_present      = 1'b1;
      sw_to_sleep     = 1'b0;
      os_req          = pwr_seq_pkg::REQ_NONE;
      lan_pins        = '0;
      t_reset();
      t_short();
      t_long();
      i_panel.press(50);
      wait_state(pwr_seq_pkg::ST_WORKING, 10);
      t_wakes();
      t_leds();
      t_ac();
      results();
   end

   // The run needs well under 10000 cycles; this cuts a hang short.
   initial begin
      #400000;
      bad_count++;
      results();
   end

endmodule
`default_nettype wire
